/* File: design/psm_pkg.sv */
// Constants for the power-save mode sequencer.
// Assumes a 32-bit APB register bus clocked by pclk.
package psm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_WAKE_EN    = 8'h04;
	localparam logic [7:0] OFF_IRQ_EN     = 8'h08;
	localparam logic [7:0] OFF_FAST_CLK   = 8'h0C;
	localparam logic [7:0] OFF_STATUS     = 8'h10;
	localparam logic [7:0] OFF_WAKE_CAUSE = 8'h14;
	localparam logic [7:0] OFF_RST_CAUSE  = 8'h18;
	localparam logic [7:0] OFF_BK_WAKE_EN = 8'h1C;
	localparam logic [7:0] OFF_BK_CAUSE   = 8'h20;

	// Control register fields
	localparam int CTRL_RET    = 0;
	localparam int CTRL_BACKUP_SELECT   = 1;
	localparam int CTRL_FAST   = 2;
	localparam int CTRL_CK32   = 3;
	localparam int CTRL_SCALING_CHANGE_REQUEST = 4;
	localparam int CTRL_PS_LO  = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int ST_POWER_STABLE     = 0;
	localparam int ST_FASTWAKE = 1;
	localparam int ST_STATE_LO = 4;

	// Reset cause bits
	localparam int NUM_RST  = 4;
	localparam int RC_ABOD  = 0;
	localparam int RC_CBOD  = 1;
	localparam int RC_WDT   = 2;
	localparam int RC_PIN   = 3;
	localparam int RC_BACKUP_SELECT  = 4;

	// Backup wake sources: external line, two brown-outs, counter, watchdog
	localparam int NUM_BK_WAKE = 5;

	// Wake cause bit for the power-stable event
	localparam int WC_POWER_STABLE = 31;

	// Power scaling settings and wake oscillators
	localparam logic [1:0] PS_RUN0    = 2'h0;
	localparam logic [1:0] PS_LIMITED = 2'h1;
	localparam logic [1:0] OSC_SYS_RC = 2'h0;

	// Default core reset latency in pclk cycles
	localparam int CORE_RST_CYC_DEF = 16;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_DEEP,
		ST_WAKE,
		ST_BACKUP,
		ST_CORE_RST,
		ST_CORE_STAB,
		ST_SCALE
	} psm_state_t;

endpackage

/* File: design/psm_sequencer.sv */
// Power-save mode sequencer: WAIT, RETENTION and BACKUP entry and exit,
// wake and reset cause recording, and regulator voltage scaling.
// Assumes all inputs synchronous to pclk; sits in the backup domain.
//
// Function
// - Wait-for-interrupt with deep sleep set and backup clear enters a deep state
// - Retention bit picks WAIT or RETENTION; core retained, synchronous clocks off
// - Deep states stop synchronous clocks; only enabled or exempt async sources wake
// - Async wake raises the manager wake interrupt with cause, or peripheral's own
// - Wake from WAIT or RETENTION returns to the RUN mode entered from
// - BACKUP powers core off; backup domain, slow clock, I/O hold stay
// - Wait-for-interrupt with deep sleep and backup set enters BACKUP
// - Brown-out, watchdog or pin reset leaves BACKUP
// - Enabled line, brown-out, counter or watchdog events also leave BACKUP
// - Slow clock select picks internal RC or crystal 32kHz source
// - Reset exit releases core reset at RUN0 voltage and flags reset cause
// - Wake exit resets only core, returns previous RUN mode after voltage stable
// - Wake exit from BACKUP sets backup flag and records backup wake cause
// - Deep-state wake waits for regulator ready unless fast wakeup is set
// - Wake uses system RC unless the fast-wake clock register selects another
// - Flash is forced to one wait state during the fast wake period
// - BACKUP wake time is core reset latency plus regulator settling
// - Scaling change applies on wait-for-interrupt, wakes on power-stable event
// - Scaling setting 1 disables USB, loops and flash programming
module psm_sequencer
	import psm_pkg::*;
#(
	parameter int         NUM_ASYNC    = 8,
	parameter logic [7:0] ASYNC_EXEMPT = 8'h03,
	parameter int         CORE_RST_CYC = CORE_RST_CYC_DEF
) (
	// Clock, reset, enable
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   ce,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Processor
	input  wire logic                   wfi,
	input  wire logic                   deep_sleep_select,
	output logic                        cpu_halt,
	// Wake and reset sources
	input  wire logic [NUM_ASYNC-1:0]   async_wake,
	input  wire logic [NUM_BK_WAKE-1:0] backup_wake,
	input  wire logic [NUM_RST-1:0]     reset_source,
	// Regulator
	input  wire logic                   vreg_ready,
	output logic [1:0]                  vreg_setting,
	output logic                        vreg_low_power,
	// Power, clocks and reset of the core domain
	output logic                        sync_clk_en,
	output logic                        core_power_en,
	output logic                        core_rst_n,
	output logic                        io_hold,
	output logic                        retention_on,
	output logic                        slow_clock_select,
	output logic [1:0]                  wake_osc_select,
	output logic                        flash_one_ws,
	output logic                        features_limited,
	output logic                        pm_wake_irq
);

	localparam int CW = $clog2(CORE_RST_CYC + 1);
	localparam logic [CW-1:0] RST_LAST = CW'(CORE_RST_CYC - 1);
	localparam logic [NUM_ASYNC-1:0] EXEMPT = ASYNC_EXEMPT[NUM_ASYNC-1:0];

	psm_state_t state_q;
	logic [31:0]            ctrl_q;
	logic [NUM_ASYNC-1:0]   wake_en_q;
	logic [31:0]            irq_en_q;
	logic [1:0]             fast_clk_q;
	logic [31:0]            wake_cause_q;
	logic [RC_BACKUP_SELECT:0]       rst_cause_q;
	logic [NUM_BK_WAKE-1:0] bk_wake_en_q;
	logic [NUM_BK_WAKE-1:0] bk_cause_q;
	logic [1:0]             run_ps_q;
	logic                   power_stable_q;
	logic                   fast_period_q;
	logic [CW-1:0]          rst_cnt_q;
	logic [31:0]            prdata_q;
	logic                   pready_q;
	logic                   pslverr_q;

	// Bus decode
	logic setup;
	logic wr;
	logic mapped;
	assign setup = psel & ~penable;
	assign wr    = psel & penable & pready_q & pwrite;
	always_comb begin
		case (paddr)
			OFF_CTRL, OFF_WAKE_EN, OFF_IRQ_EN, OFF_FAST_CLK, OFF_STATUS,
			OFF_WAKE_CAUSE, OFF_RST_CAUSE, OFF_BK_WAKE_EN, OFF_BK_CAUSE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Wake qualification
	logic [NUM_ASYNC-1:0]   deep_hits;
	logic [NUM_BK_WAKE-1:0] bk_hits;
	logic                   any_reset;
	assign deep_hits = async_wake & (wake_en_q | EXEMPT);
	assign bk_hits   = backup_wake & bk_wake_en_q;
	assign any_reset = |reset_source;

	logic [1:0] ps_field;
	assign ps_field = ctrl_q[CTRL_PS_LO +: 2];

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= ST_RUN;
			rst_cnt_q <= '0;
			run_ps_q  <= PS_RUN0;
		end else if (ce) begin
			case (state_q)
				ST_RUN: begin
					if (any_reset) begin
						state_q   <= ST_CORE_RST;
						rst_cnt_q <= '0;
						run_ps_q  <= PS_RUN0;
					end else if (wfi && ctrl_q[CTRL_SCALING_CHANGE_REQUEST]) begin
						state_q  <= ST_SCALE;
						run_ps_q <= ps_field;
					end else if (wfi && deep_sleep_select && !ctrl_q[CTRL_BACKUP_SELECT]) begin
						state_q <= ST_DEEP;
					end else if (wfi && deep_sleep_select && ctrl_q[CTRL_BACKUP_SELECT]) begin
						state_q <= ST_BACKUP;
					end
				end
				ST_DEEP: begin
					if (any_reset) begin
						state_q   <= ST_CORE_RST;
						rst_cnt_q <= '0;
						run_ps_q  <= PS_RUN0;
					end else if (|deep_hits) begin
						state_q <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					// A reset still wins over the pending return to RUN
					if (any_reset) begin
						state_q   <= ST_CORE_RST;
						rst_cnt_q <= '0;
						run_ps_q  <= PS_RUN0;
					end else if (ctrl_q[CTRL_FAST] || vreg_ready) begin
						// Fast wakeup lets the core run before the regulator settles
						state_q <= ST_RUN;
					end
				end
				ST_BACKUP: begin
					if (any_reset) begin
						state_q   <= ST_CORE_RST;
						rst_cnt_q <= '0;
						run_ps_q  <= PS_RUN0;
					end else if (|bk_hits) begin
						state_q   <= ST_CORE_RST;
						rst_cnt_q <= '0;
					end
				end
				ST_CORE_RST: begin
					rst_cnt_q <= rst_cnt_q + 1'b1;
					if (rst_cnt_q == RST_LAST) begin
						state_q <= ST_CORE_STAB;
					end
				end
				ST_CORE_STAB: begin
					if (vreg_ready) begin
						state_q <= ST_RUN;
					end
				end
				ST_SCALE: begin
					// Reset breaks a scaling wait that never settles
					if (any_reset) begin
						state_q   <= ST_CORE_RST;
						rst_cnt_q <= '0;
						run_ps_q  <= PS_RUN0;
					end else if (vreg_ready) begin
						state_q <= ST_RUN;
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// Power and clock outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_halt       <= 1'b0;
			sync_clk_en    <= 1'b1;
			core_power_en  <= 1'b1;
			core_rst_n     <= 1'b0;
			io_hold        <= 1'b0;
			retention_on   <= 1'b0;
			vreg_low_power <= 1'b0;
			vreg_setting   <= PS_RUN0;
		end else if (ce) begin
			cpu_halt       <= state_q != ST_RUN;
			sync_clk_en    <= state_q != ST_DEEP && state_q != ST_BACKUP;
			core_power_en  <= state_q != ST_BACKUP;
			// Core reset holds until the regulator has settled
			core_rst_n     <= state_q != ST_BACKUP && state_q != ST_CORE_RST &&
				state_q != ST_CORE_STAB;
			io_hold        <= state_q == ST_BACKUP;
			retention_on   <= state_q == ST_DEEP && ctrl_q[CTRL_RET];
			vreg_low_power <= state_q == ST_DEEP || state_q == ST_BACKUP;
			vreg_setting   <= (state_q == ST_SCALE) ? ps_field : run_ps_q;
		end
	end

	// Regulator status and fast wake period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_stable_q <= 1'b1;
			fast_period_q  <= 1'b0;
		end else if (ce) begin
			if (state_q == ST_SCALE || state_q == ST_DEEP || state_q == ST_BACKUP ||
				state_q == ST_CORE_RST) begin
				power_stable_q <= 1'b0;
			end else if (vreg_ready) begin
				power_stable_q <= 1'b1;
			end
			if (state_q == ST_WAKE && ctrl_q[CTRL_FAST] && !vreg_ready) begin
				fast_period_q <= 1'b1;
			end else if (vreg_ready) begin
				fast_period_q <= 1'b0;
			end
		end
	end

	// Clock selection and feature gating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_clock_select <= 1'b0;
			wake_osc_select   <= OSC_SYS_RC;
			flash_one_ws      <= 1'b0;
			features_limited  <= 1'b0;
		end else if (ce) begin
			slow_clock_select <= ctrl_q[CTRL_CK32];
			// Software must not move off this oscillator before power stable
			wake_osc_select   <= (state_q == ST_WAKE || fast_period_q) ?
				fast_clk_q : OSC_SYS_RC;
			flash_one_ws      <= fast_period_q ||
				(state_q == ST_WAKE && ctrl_q[CTRL_FAST]);
			features_limited  <= run_ps_q == PS_LIMITED;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q       <= CTRL_RESET;
			wake_en_q    <= '0;
			irq_en_q     <= '0;
			fast_clk_q   <= OSC_SYS_RC;
			bk_wake_en_q <= '0;
		end else if (ce) begin
			if (wr && paddr == OFF_CTRL) begin
				ctrl_q <= pwdata & 32'h0000_007F;
			end else if (state_q == ST_SCALE && (vreg_ready || any_reset)) begin
				ctrl_q[CTRL_SCALING_CHANGE_REQUEST] <= 1'b0;
			end else if (state_q == ST_CORE_RST && run_ps_q == PS_RUN0) begin
				ctrl_q[CTRL_PS_LO +: 2] <= PS_RUN0;
			end
			if (wr && paddr == OFF_WAKE_EN) begin
				wake_en_q <= pwdata[NUM_ASYNC-1:0];
			end
			if (wr && paddr == OFF_IRQ_EN) begin
				irq_en_q <= pwdata;
			end
			if (wr && paddr == OFF_FAST_CLK) begin
				fast_clk_q <= pwdata[1:0];
			end
			if (wr && paddr == OFF_BK_WAKE_EN) begin
				bk_wake_en_q <= pwdata[NUM_BK_WAKE-1:0];
			end
		end
	end

	// Cause registers: write one to clear, a new event wins over the clear
	logic [31:0]            wc_set;
	logic [RC_BACKUP_SELECT:0]       rc_set;
	logic [NUM_BK_WAKE-1:0] bc_set;
	always_comb begin
		wc_set = '0;
		if (state_q == ST_DEEP) begin
			wc_set[NUM_ASYNC-1:0] = deep_hits;
		end
		wc_set[WC_POWER_STABLE] = state_q == ST_SCALE && vreg_ready && !any_reset;
		rc_set = '0;
		if (state_q != ST_CORE_RST && state_q != ST_CORE_STAB) begin
			rc_set[NUM_RST-1:0] = reset_source;
		end
		rc_set[RC_BACKUP_SELECT] = state_q == ST_BACKUP && !any_reset && |bk_hits;
		bc_set = (state_q == ST_BACKUP && !any_reset) ? bk_hits : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cause_q <= '0;
			rst_cause_q  <= '0;
			bk_cause_q   <= '0;
		end else if (ce) begin
			wake_cause_q <= (wake_cause_q &
				~((wr && paddr == OFF_WAKE_CAUSE) ? pwdata : 32'h0)) | wc_set;
			rst_cause_q  <= (rst_cause_q &
				~((wr && paddr == OFF_RST_CAUSE) ? pwdata[RC_BACKUP_SELECT:0] : '0)) | rc_set;
			bk_cause_q   <= (bk_cause_q &
				~((wr && paddr == OFF_BK_CAUSE) ? pwdata[NUM_BK_WAKE-1:0] : '0)) | bc_set;
		end
	end

	// Manager wake interrupt; a peripheral may raise its own instead
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_wake_irq <= 1'b0;
		end else if (ce) begin
			pm_wake_irq <= |(wake_cause_q & irq_en_q);
		end
	end

	// APB read data and response, loaded in the setup cycle
	logic [31:0] rdata;
	always_comb begin
		rdata = '0;
		case (paddr)
			OFF_CTRL:       rdata = ctrl_q;
			OFF_WAKE_EN:    rdata[NUM_ASYNC-1:0] = wake_en_q;
			OFF_IRQ_EN:     rdata = irq_en_q;
			OFF_FAST_CLK:   rdata[1:0] = fast_clk_q;
			OFF_STATUS: begin
				rdata[ST_POWER_STABLE]            = power_stable_q;
				rdata[ST_FASTWAKE]        = fast_period_q;
				rdata[ST_STATE_LO +: 3]   = state_q;
			end
			OFF_WAKE_CAUSE: rdata = wake_cause_q;
			OFF_RST_CAUSE:  rdata[RC_BACKUP_SELECT:0] = rst_cause_q;
			OFF_BK_WAKE_EN: rdata[NUM_BK_WAKE-1:0] = bk_wake_en_q;
			OFF_BK_CAUSE:   rdata[NUM_BK_WAKE-1:0] = bk_cause_q;
			default:        rdata = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else if (ce) begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup && !pwrite) begin
				prdata_q <= rdata;
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule // psm_sequencer

/* File: tb/psm_sequencer_assertions.sv */
// Port checker for the power-save sequencer.
// Assumes binding to psm_sequencer; checks pause while ce is low.
module psm_sequencer_checker
	import psm_pkg::*;
#(
	parameter int CORE_RST_CYC = CORE_RST_CYC_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Bus and processor
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic wfi,
	input wire logic deep_sleep_select,
	input wire logic cpu_halt,
	// Power and clocks
	input wire logic vreg_ready,
	input wire logic vreg_low_power,
	input wire logic sync_clk_en,
	input wire logic core_power_en,
	input wire logic core_rst_n,
	input wire logic io_hold,
	input wire logic retention_on
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	logic [15:0] low_cnt_q;
	logic        up_q;

	// Powered core reset length; first release after presetn is skipped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_q <= 16'h0000;
			up_q      <= 1'b0;
		end else begin
			low_cnt_q <= (core_rst_n || !core_power_en) ? 16'h0000 : low_cnt_q + 16'h0001;
			up_q      <= up_q | core_rst_n;
		end
	end

	a_deep_entry: assert property (wfi && deep_sleep_select && !cpu_halt |-> ##2 cpu_halt)
		else $error("cpu not halted after deep wfi");
	a_clk_stop: assert property (!sync_clk_en |-> cpu_halt)
		else $error("sync clocks stopped while running");
	a_backup_hold: assert property (!core_power_en |-> io_hold && !core_rst_n && !sync_clk_en)
		else $error("core off without hold and reset");
	a_low_power: assert property (vreg_low_power |-> cpu_halt)
		else $error("low power regulator while running");
	a_retain_on: assert property (retention_on |-> core_power_en && !sync_clk_en)
		else $error("retention outside deep state");
	a_release_stable: assert property ($rose(core_rst_n) |-> $past(vreg_ready, 2))
		else $error("core reset released before regulator ready");
	a_core_rst_len: assert property ($rose(core_rst_n) && up_q |-> low_cnt_q >= CORE_RST_CYC)
		else $error("core reset too short");
	a_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
endmodule // psm_sequencer_checker

bind psm_sequencer psm_sequencer_checker #(.CORE_RST_CYC(CORE_RST_CYC)) psm_sequencer_checker_inst (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
	.wfi(wfi), .deep_sleep_select(deep_sleep_select), .cpu_halt(cpu_halt),
	.vreg_ready(vreg_ready), .vreg_low_power(vreg_low_power), .sync_clk_en(sync_clk_en),
	.core_power_en(core_power_en), .core_rst_n(core_rst_n), .io_hold(io_hold),
	.retention_on(retention_on)
);

/* File: tb/test_psm_sequencer.sv */
// Self-checking bench for the power-save sequencer.
// Assumes the bench drives every port itself; ce is dropped once to test the freeze.
module test_psm_sequencer
	import psm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, wfi, deep_sleep_select, vreg_ready;
	logic        pready, pslverr, cpu_halt, vreg_low_power, sync_clk_en, core_power_en;
	logic        core_rst_n, io_hold, retention_on, slow_clock_select, flash_one_ws;
	logic        features_limited, pm_wake_irq, last_err, ce;
	logic [7:0]  paddr, async_wake;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  backup_wake;
	logic [3:0]  reset_source;
	logic [1:0]  vreg_setting, wake_osc_select;
	int          num_errors, compares;

	psm_sequencer #(.CORE_RST_CYC(4)) psm_sequencer_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wfi(wfi), .deep_sleep_select(deep_sleep_select),
		.cpu_halt(cpu_halt), .async_wake(async_wake), .backup_wake(backup_wake),
		.reset_source(reset_source), .vreg_ready(vreg_ready), .vreg_setting(vreg_setting),
		.vreg_low_power(vreg_low_power), .sync_clk_en(sync_clk_en),
		.core_power_en(core_power_en), .core_rst_n(core_rst_n), .io_hold(io_hold),
		.retention_on(retention_on), .slow_clock_select(slow_clock_select),
		.wake_osc_select(wake_osc_select), .flash_one_ws(flash_one_ws),
		.features_limited(features_limited), .pm_wake_irq(pm_wake_irq)
	);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// Request held until ready is seen at an edge; an idle edge follows
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic wfi_pulse();
		wfi <= 1'b1;
		@(posedge pclk);
		wfi <= 1'b0;
	endtask

	// Bounded wait for the core to run again
	task automatic wait_run();
		for (int i = 0; i < 200 && (cpu_halt !== 1'b0 || core_rst_n !== 1'b1); i++) begin
			@(posedge pclk);
		end
		chkb(cpu_halt, 1'b0);
	endtask

	// Whole run needs a few hundred cycles; this leaves wide margin
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end

	initial begin
		{presetn, psel, penable, pwrite, wfi, deep_sleep_select} = 6'h00;
		{paddr, async_wake, pwdata, backup_wake, reset_source} = 57'h0;
		vreg_ready = 1'b1;
		ce = 1'b1;
		num_errors = 0;
		compares = 0;
		cyc(10);
		presetn <= 1'b1;
		cyc(2);
		chkb(core_rst_n, 1'b1);
		chkb(core_power_en, 1'b1);
		rchk(OFF_CTRL, CTRL_RESET);
		rchk(8'h40, 32'h0);
		chkb(last_err, 1'b1);
		// Without deep sleep the request is not handled here
		wfi_pulse();
		cyc(3);
		chkb(cpu_halt, 1'b0);
		wr(OFF_CTRL, 32'h8);
		cyc(2);
		chkb(slow_clock_select, 1'b1);
		deep_sleep_select <= 1'b1;
		// Clock enable low freezes the sequencer, so this request is lost
		ce <= 1'b0;
		wfi_pulse();
		cyc(2);
		ce <= 1'b1;
		cyc(3);
		chkb(cpu_halt, 1'b0);
		for (int r = 0; r < 2; r++) begin
			wr(OFF_CTRL, 32'(r));
			wr(OFF_WAKE_EN, 32'h0);
			wr(OFF_IRQ_EN, 32'h4);
			wfi_pulse();
			cyc(3);
			chkb(sync_clk_en, 1'b0);
			chkb(retention_on, r[0]);
			async_wake <= 8'h04;
			cyc(4);
			chkb(cpu_halt, 1'b1);
			wr(OFF_WAKE_EN, 32'h4);
			wait_run();
			async_wake <= 8'h00;
			rchk(OFF_WAKE_CAUSE, 32'h4);
			chkb(pm_wake_irq, 1'b1);
			wr(OFF_WAKE_CAUSE, 32'h4);
			cyc(2);
			chkb(pm_wake_irq, 1'b0);
		end
		rchk(OFF_STATUS, 32'h1);
		wr(OFF_WAKE_EN, 32'h8000_0000);
		wr(OFF_IRQ_EN, 32'h8000_0000);
		wr(OFF_CTRL, 32'h30);
		wfi_pulse();
		vreg_ready <= 1'b0;
		cyc(6);
		chkb(cpu_halt, 1'b1);
		chkb(vreg_setting == PS_LIMITED, 1'b1);
		vreg_ready <= 1'b1;
		wait_run();
		chkb(features_limited, 1'b1);
		rchk(OFF_WAKE_CAUSE, 32'h8000_0000);
		chkb(pm_wake_irq, 1'b1);
		rchk(OFF_CTRL, 32'h20);
		wr(OFF_WAKE_CAUSE, 32'hFFFF_FFFF);
		// Fast wake returns before the regulator settles
		wr(OFF_WAKE_EN, 32'h0);
		wr(OFF_FAST_CLK, 32'h1);
		wr(OFF_CTRL, 32'h24);
		wfi_pulse();
		vreg_ready <= 1'b0;
		cyc(3);
		async_wake <= 8'h01;
		wait_run();
		async_wake <= 8'h00;
		chkb(flash_one_ws, 1'b1);
		chkb(features_limited, 1'b1);
		chk({30'h0, wake_osc_select}, 32'h1);
		rchk(OFF_STATUS, 32'h2);
		vreg_ready <= 1'b1;
		cyc(4);
		chkb(flash_one_ws, 1'b0);
		chk({30'h0, wake_osc_select}, 32'h0);
		rchk(OFF_STATUS, 32'h1);
		wr(OFF_RST_CAUSE, 32'h1F);
		wr(OFF_BK_WAKE_EN, 32'h1);
		wr(OFF_CTRL, 32'h22);
		wfi_pulse();
		cyc(3);
		chkb(core_power_en, 1'b0);
		chkb(io_hold, 1'b1);
		backup_wake <= 5'h02;
		cyc(3);
		chkb(core_power_en, 1'b0);
		// Core reset is held while the regulator is still settling
		vreg_ready <= 1'b0;
		backup_wake <= 5'h01;
		cyc(10);
		chkb(core_rst_n, 1'b0);
		vreg_ready <= 1'b1;
		wait_run();
		backup_wake <= 5'h00;
		chkb(features_limited, 1'b1);
		rchk(OFF_RST_CAUSE, 32'h10);
		rchk(OFF_BK_CAUSE, 32'h1);
		for (int i = 0; i < NUM_RST; i++) begin
			wr(OFF_RST_CAUSE, 32'h1F);
			wr(OFF_CTRL, 32'h22);
			wfi_pulse();
			cyc(3);
			reset_source <= 4'(1 << i);
			cyc(1);
			reset_source <= 4'h0;
			wait_run();
			chkb(features_limited, 1'b0);
			rchk(OFF_RST_CAUSE, 32'(1 << i));
		end
		give_verdict();
	end
endmodule // test_psm_sequencer
